// file: design/qadc_pkg.sv
// Purpose: Shared constants and types for the four-channel converter host port
// Assumes: Single clock mclk at 200 MHz
// Notes: Conversion clock arrives as a pin and is sampled, not used as a clock
package qadc_pkg;
	// ==========================================
	// Widths and counts
	localparam int QADC_RES_W = 12;
	localparam int QADC_CH_W = 2;
	localparam int QADC_BUS_W = 8;
	localparam int QADC_NBITS = 12;
	localparam logic [QADC_RES_W-1:0] QADC_RES_RST = 12'h000;
	localparam logic [QADC_CH_W-1:0] QADC_CH_RST = 2'h0;
	// Falling conversion clock edge count at which the most significant bit is decided
	localparam logic [1:0] QADC_MSB_EDGE = 2'h2;
	// ==========================================
	// Timing
	localparam int QADC_MCLK_MHZ = 200;
	localparam int QADC_EXT_WR_US = 10;
	localparam int QADC_EXT_WR_CYC = QADC_EXT_WR_US * QADC_MCLK_MHZ;

	typedef enum logic [1:0] {QADC_IDLE, QADC_ZERO, QADC_WAIT, QADC_CONV} qadc_state_e;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic byte_select;
		logic channel_sel_hi;
		logic channel_sel_lo;
		logic conv_clk;
	} qadc_pins_s;

	typedef struct packed {
		logic [QADC_BUS_W-1:0] data;
		logic [QADC_BUS_W-1:0] data_oe;
	} qadc_bus_s;
endpackage

// file: design/qadc_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs asynchronous to mclk
// Notes: Stage one is read only by stage two
`timescale 1ns/100ps
module qadc_sync import qadc_pkg::*; #(
	parameter int W = 7
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	input wire logic [W-1:0] rst_val,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} qadc_sync_s;
	qadc_sync_s st_r, st_nxt;
	// Refuse an empty group
	if (W < 1) begin : g_bad_width
		$error("qadc_sync width must be at least one");
	end
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{s1: {W{1'b1}}, s2: {W{1'b1}}};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
	logic unused_rst;
	assign unused_rst = ^rst_val;
endmodule // qadc_sync

// file: design/qadc_host_port.sv
// Purpose: Control logic and host bus port of a four-channel 12-bit converter
// Assumes: Comparator result arrives as comp_high on mclk; conv_clk is a pin
// Notes: Data bus is split into data, enable
// Function
// - Drive data only with select and read low
// - High byte: msb nibble, zeros, status top
// - Low byte: result bits 7..0
// - Hold twelve-bit unsigned result, bit 11 msb
// - Bus status flag high while converting
// - Busy output low while converting
// - Write with select low starts conversion
// - Address latch transparent while writing, rising capture
// - Address value directly names the channel
// - Idle means autozero phase
// - Write falling edge switches the multiplexer
// - Either byte order, reads are independent
// - Byte select change updates driven byte
// - Single conversion clock input, either source
// - New start aborts running conversion
// - Read during conversion shows partial register
// - Msb decided second falling edge after write
// - Twelve clock cycles, one bit each
`timescale 1ns/100ps
module qadc_host_port import qadc_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire qadc_pins_s pins,
	input wire logic comp_high,
	output qadc_bus_s bus,
	output logic busy_n,
	output logic [QADC_CH_W-1:0] mux_channel,
	output logic autozero,
	output logic [QADC_RES_W-1:0] dac_code
);
	typedef struct packed {
		qadc_state_e state;
		logic [QADC_RES_W-1:0] sar;
		logic [3:0] bit_idx;
		logic [1:0] edges;
		logic [QADC_CH_W-1:0] ch_latch;
		logic [QADC_CH_W-1:0] mux;
		logic wr_d;
		logic clk_d;
		qadc_bus_s bus;
	} qadc_st_s;

	qadc_st_s st_r, st_nxt;
	qadc_pins_s sp;

	// ==========================================
	// Pin synchronisers
	qadc_sync #(.W($bits(qadc_pins_s))) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.d(pins),
		.rst_val('1),
		.q(sp)
	);

	logic wr_act, wr_fall, wr_rise, clk_fall, rd_act;
	logic [QADC_CH_W-1:0] ch_live;
	logic [QADC_BUS_W-1:0] hi_byte, lo_byte;
	logic converting;

	always_comb begin
		wr_act = !sp.cs_n && !sp.wr_n;
		wr_fall = wr_act && !st_r.wr_d;
		wr_rise = !wr_act && st_r.wr_d;
		clk_fall = st_r.clk_d && !sp.conv_clk;
		rd_act = !sp.cs_n && !sp.rd_n;
		converting = (st_r.state != QADC_IDLE);
		ch_live = wr_act ? {sp.channel_sel_hi, sp.channel_sel_lo} : st_r.ch_latch;
		hi_byte = {converting, 3'h0, st_r.sar[11:8]};
		lo_byte = st_r.sar[7:0];
	end

	// ==========================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.wr_d = wr_act;
		st_nxt.clk_d = sp.conv_clk;
		st_nxt.ch_latch = ch_live;
		if (wr_fall) begin
			st_nxt.mux = {sp.channel_sel_hi, sp.channel_sel_lo};
		end
		if (wr_act && st_r.wr_d) begin
			st_nxt.mux = ch_live;
		end
		if (wr_act) begin
			// Start or restart, autozero while write held
			st_nxt.state = QADC_ZERO;
			st_nxt.sar = QADC_RES_RST;
			st_nxt.bit_idx = 4'hB;
			st_nxt.edges = 2'h0;
		end else begin
			case (st_r.state)
				QADC_IDLE: begin
				end
				QADC_ZERO: begin
					if (wr_rise) begin
						st_nxt.state = QADC_WAIT;
						st_nxt.sar[11] = 1'b1;
					end
				end
				QADC_WAIT: begin
					if (clk_fall) begin
						st_nxt.edges = st_r.edges + 2'h1;
						if (st_r.edges + 2'h1 == QADC_MSB_EDGE) begin
							st_nxt.state = QADC_CONV;
							st_nxt.sar[11] = comp_high;
							if (QADC_NBITS > 1) begin
								st_nxt.sar[10] = 1'b1;
							end
							st_nxt.bit_idx = 4'hA;
						end
					end
				end
				QADC_CONV: begin
					if (clk_fall) begin
						st_nxt.sar[st_r.bit_idx] = comp_high;
						if (st_r.bit_idx == 4'h0) begin
							st_nxt.state = QADC_IDLE;
						end else begin
							st_nxt.sar[st_r.bit_idx - 4'h1] = 1'b1;
							st_nxt.bit_idx = st_r.bit_idx - 4'h1;
						end
					end
				end
				default: st_nxt.state = QADC_IDLE;
			endcase
		end
		st_nxt.bus.data = sp.byte_select ? hi_byte : lo_byte;
		st_nxt.bus.data_oe = rd_act ? '1 : '0;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{state: QADC_IDLE, sar: QADC_RES_RST, bit_idx: 4'hB, edges: 2'h0,
				ch_latch: QADC_CH_RST, mux: QADC_CH_RST, wr_d: 1'b0, clk_d: 1'b1,
				bus: '{data: 8'h00, data_oe: 8'h00}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus = st_r.bus;
	assign busy_n = !converting;
	assign autozero = (st_r.state == QADC_IDLE) || (st_r.state == QADC_ZERO);
	assign mux_channel = st_r.mux;
	assign dac_code = st_r.sar;

	// ==========================================
	// Assertions
	sequence s_msb_edge;
		clk_fall && st_r.state == QADC_WAIT && st_r.edges == 2'h1 && !wr_act;
	endsequence
	a_bus_enable: assert property (@(posedge mclk) disable iff (!reset_n)
		1 |=> (bus.data_oe == (($past(rd_act)) ? 8'hFF : 8'h00)))
		else $error("data enable wrong");
	a_high_byte: assert property (@(posedge mclk) disable iff (!reset_n)
		sp.byte_select |=> bus.data[6:4] == 3'h0 && bus.data[7] == $past(converting)
		&& bus.data[3:0] == $past(st_r.sar[11:8]))
		else $error("high byte layout wrong");
	a_low_byte: assert property (@(posedge mclk) disable iff (!reset_n)
		!sp.byte_select |=> bus.data == $past(st_r.sar[7:0]))
		else $error("low byte wrong");
	a_busy_pin: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(busy_n) |-> $past(wr_act))
		else $error("busy output wrong");
	a_busy_release: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(busy_n) |-> $past(st_r.state == QADC_CONV && st_r.bit_idx == 4'h0 && clk_fall))
		else $error("busy released early");
	a_start_conv: assert property (@(posedge mclk) disable iff (!reset_n)
		wr_act |=> !busy_n && st_r.state == QADC_ZERO)
		else $error("write did not start");
	a_mux_switch: assert property (@(posedge mclk) disable iff (!reset_n)
		wr_fall |=> mux_channel == $past({sp.channel_sel_hi, sp.channel_sel_lo}))
		else $error("mux not switched");
	a_addr_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		!wr_act && !$past(wr_act) |=> $stable(st_r.ch_latch))
		else $error("address latch moved");
	a_msb_time: assert property (@(posedge mclk) disable iff (!reset_n)
		s_msb_edge |=> st_r.state == QADC_CONV && st_r.bit_idx == 4'hA)
		else $error("msb not decided");
	a_finish: assert property (@(posedge mclk) disable iff (!reset_n)
		st_r.state == QADC_CONV && st_r.bit_idx == 4'h0 && clk_fall && !wr_act
		|=> busy_n && autozero)
		else $error("completion wrong");
endmodule // qadc_host_port

// file: verif/qadc_analog_model.sv
// Purpose: Analog side model: comparator and external conversion clock
// Assumes: Input level stays steady during a conversion
// Notes: Clock half period in mclk cycles is a parameter
`timescale 1ns/100ps
module qadc_analog_model import qadc_pkg::*; #(
	parameter int HALF = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [QADC_RES_W-1:0] vin,
	input wire logic [QADC_RES_W-1:0] dac_code,
	output logic conv_clk,
	output logic comp_high
);
	int cnt;
	// ==========================================
	// Free-running external clock source
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			conv_clk <= 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			conv_clk <= !conv_clk;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign comp_high = (vin >= dac_code);
endmodule // qadc_analog_model

// file: verif/quad_channel_adc_host_port_tb.sv
// Purpose: Self-checking bench for the converter host port
// Assumes: Comparator model closes the loop on dac_code
// Notes: Host pins driven at the falling edge of mclk
`timescale 1ns/100ps
module quad_channel_adc_host_port_tb import qadc_pkg::*;;
	logic mclk, reset_n, conv_clk, comp_high, busy_n, autozero;
	logic [1:0] mux_channel;
	logic [11:0] dac_code, vin, v;
	qadc_pins_s hp;
	qadc_bus_s bus;
	int failures, checked, cycles;
	// Conversion clock period in mclk cycles
	localparam int CLK_PER = 16;
	qadc_host_port DUT (.mclk(mclk), .reset_n(reset_n),
		.pins(qadc_pins_s'({hp[6:1], conv_clk})), .comp_high(comp_high), .bus(bus),
		.busy_n(busy_n), .mux_channel(mux_channel), .autozero(autozero), .dac_code(dac_code));
	qadc_analog_model #(.HALF(CLK_PER / 2)) u_ana (.mclk(mclk), .reset_n(reset_n), .vin(vin),
		.dac_code(dac_code), .conv_clk(conv_clk), .comp_high(comp_high));
	always #2.5 mclk = ~mclk;
	// ==========================================
	// Tasks
	task automatic results;
		$display("Checks made %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [7:0] exp_byte(logic [11:0] r, bit hi);
		return hi ? {4'h0, r[11:8]} : r[7:0];
	endfunction
	task automatic conv(logic [1:0] ch, logic [11:0] x);
		@(negedge mclk);
		vin = x;
		hp.cs_n = 1'b0;
		hp.wr_n = 1'b0;
		{hp.channel_sel_hi, hp.channel_sel_lo} = ch;
		repeat (QADC_EXT_WR_CYC) @(negedge mclk);
		chk("mux", ch, mux_channel);
		chk("busy_n", 0, busy_n);
		hp.wr_n = 1'b1;
		hp.cs_n = 1'b1;
		@(negedge mclk);
		{hp.channel_sel_hi, hp.channel_sel_lo} = ~ch;
	endtask
	task automatic rd(logic [11:0] x, bit hi);
		@(negedge mclk);
		hp.cs_n = 1'b0;
		hp.rd_n = 1'b0;
		hp.byte_select = hi;
		repeat (4) @(negedge mclk);
		chk("oe", 8'hFF, bus.data_oe);
		chk("byte", exp_byte(x, hi), bus.data);
		hp.byte_select = !hi;
		repeat (4) @(negedge mclk);
		chk("byte", exp_byte(x, !hi), bus.data);
		hp.cs_n = 1'b1;
		hp.rd_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk("oe", 8'h00, bus.data_oe);
	endtask
	task automatic done(logic [1:0] ch, logic [11:0] x);
		int n;
		n = 0;
		while (busy_n !== 1'b1 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		chk("busy_n", 1, busy_n);
		chk("len", 1, n >= QADC_NBITS * CLK_PER &&
			n <= (QADC_NBITS + 1) * CLK_PER + 8);
		chk("autozero", 1, autozero);
		chk("mux", ch, mux_channel);
		rd(x, $urandom_range(0, 1));
	endtask
	// ==========================================
	// Timeout
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			results;
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		hp = '1;
		vin = 12'h000;
		void'($urandom(28807));
		repeat (6) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk("oe", 8'h00, bus.data_oe);
		chk("busy_n", 1, busy_n);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom_range(0, 4095));
			conv(i[1:0], v);
			done(i[1:0], v);
			$display("Test %0d finished", i);
		end
		conv(2'h1, 12'h5A5);
		repeat (100) @(negedge mclk);
		hp.cs_n = 1'b0;
		hp.rd_n = 1'b0;
		hp.byte_select = 1'b1;
		repeat (4) @(negedge mclk);
		chk("flag", 4'h8, bus.data[7:4]);
		hp.cs_n = 1'b1;
		hp.rd_n = 1'b1;
		conv(2'h2, 12'hA5A);
		done(2'h2, 12'hA5A);
		$display("Test abort finished");
		results;
	end
endmodule // quad_channel_adc_host_port_tb
